// File: rtl/mtcs_pkg.sv
// Constants and carrier types for the transmit setup and result block
package mtcs_pkg;

    // ==========================================================
    // Register map: printed offsets are indices, byte address is four times
    localparam logic [7:0] IDX_RESULT = 8'h04;
    localparam logic [7:0] IDX_SETUP = 8'h0d;
    localparam logic [7:0] IDX_CLASH = 8'h05;
    localparam logic [7:0] ADDR_RESULT = 8'(IDX_RESULT * 4);
    localparam logic [7:0] ADDR_SETUP = 8'(IDX_SETUP * 4);
    localparam logic [7:0] ADDR_CLASH = 8'(IDX_CLASH * 4);

    // ==========================================================
    // Setup fields
    localparam int SET_CRC_INHIBIT = 0;
    localparam int SET_LOOP_LO = 1;
    localparam int SET_LOOP_HI = 2;
    localparam int SET_REMOTE_DIS = 3;
    localparam int SET_OFFSET = 4;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] SETUP_MASK = 8'h1f;
    localparam logic [1:0] LOOP_NORMAL = 2'h0;
    localparam logic [1:0] LOOP_INTERNAL = 2'h1;
    localparam logic [1:0] LOOP_EXT_PIN = 2'h2;

    // ==========================================================
    // Result fields
    localparam int RES_SENT_OK = 0;
    localparam int RES_COLLIDED = 2;
    localparam int RES_GAVE_UP = 3;
    localparam int RES_CARRIER = 4;
    localparam int RES_UNDERRUN = 5;
    localparam int RES_HEARTBEAT = 6;
    localparam int RES_LATE = 7;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam int CLASH_TX_EN = 7;

    // ==========================================================
    // Collision handling
    localparam logic [4:0] ABORT_ATTEMPTS = 5'h10;
    localparam logic [4:0] OFFSET_COLLISIONS = 5'h03;
    localparam logic [4:0] OFFSET_ADD = 5'h03;
    localparam logic [4:0] BACKOFF_MAX_EXP = 5'h0a;
    localparam logic [5:0] HASH_DISABLE = 6'h3e;
    localparam logic [5:0] HASH_ENABLE = 6'h3f;
    localparam logic [15:0] LFSR_SEED = 16'hace1;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int HB_WINDOW_NS = 6400;
    localparam int SLOT_TIME_NS = 51200;
    localparam int HB_CYCLES = HB_WINDOW_NS / CLK_PERIOD_NS;
    localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] HB_LAST = 7'(HB_CYCLES - 1);
    localparam logic [9:0] SLOT_COUNT = 10'(SLOT_CYCLES);

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_SEND = 2'h1,
        PH_GAP = 2'h3
    } mtcs_phase_e;

    typedef struct packed {
        logic start;
        logic preamble_done;
        logic done;
        logic underrun;
        logic col;
        logic carrier_lost_flag;
        logic transmit_drive_enable;
        logic mcast_hit;
        logic [5:0] mcast_idx;
    } mtcs_line_in_s;

    typedef struct packed {
        logic crc_append;
        logic internal_loop;
        logic external_loop;
        logic loop_pin;
        logic tx_enabled;
        logic abort_frame;
        logic backoff_valid;
        logic [9:0] backoff_slots;
    } mtcs_line_out_s;

endpackage

// File: rtl/mtcs_top.sv
// Transmit setup and result registers with collision, carrier and heartbeat tracking
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module mtcs_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire mtcs_pkg::mtcs_line_in_s line_in,
    output mtcs_pkg::mtcs_line_out_s line_out
);

    // ==========================================================
    // Bus slave
    logic wait_r;
    logic wait_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [7:0] setup_r;
    logic [7:0] setup_nxt;
    logic [7:0] result_r;
    logic [4:0] clash_cnt_r;
    logic [4:0] clash_cnt_nxt;
    logic tx_en_r;
    logic tx_en_nxt;

    wire req = avs_read | avs_write;
    wire hit_result = avs_address == mtcs_pkg::ADDR_RESULT;
    wire hit_setup = avs_address == mtcs_pkg::ADDR_SETUP;
    wire hit_clash = avs_address == mtcs_pkg::ADDR_CLASH;
    wire setup_wr = avs_write & ~wait_r & hit_setup & avs_byteenable[0];
    wire [31:0] clash_word = {24'h00_0000, tx_en_r, 2'h0, clash_cnt_r};
    // Setup is write-only; reads of it and of holes return zero
    wire [31:0] read_word = hit_result ? {24'h00_0000, result_r} :
                            hit_clash ? clash_word : 32'h0000_0000;

    // One wait state: answer on the edge after the request is first seen
    assign wait_nxt = ~(req & wait_r);
    assign rdata_nxt = (avs_read & wait_r) ? read_word : rdata_r;
    assign setup_nxt = setup_wr ? (avs_writedata[7:0] & mtcs_pkg::SETUP_MASK) : setup_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            setup_r <= mtcs_pkg::SETUP_RST;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            setup_r <= setup_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // ==========================================================
    // Line events
    mtcs_pkg::mtcs_phase_e phase_r;
    mtcs_pkg::mtcs_phase_e phase_nxt;
    logic col_d_r;
    logic watch_r;
    logic hb_seen_r;
    logic [9:0] slot_cnt_r;
    logic [6:0] gap_cnt_r;
    logic [15:0] lfsr_r;
    logic [7:0] set_vec;
    mtcs_pkg::mtcs_line_out_s ctl_r;
    mtcs_pkg::mtcs_line_out_s ctl_nxt;

    wire col_edge = line_in.col & ~col_d_r & line_in.transmit_drive_enable;
    wire late_hit = col_edge & (slot_cnt_r >= mtcs_pkg::SLOT_COUNT);
    wire abort_coll = col_edge & (clash_cnt_r == mtcs_pkg::ABORT_ATTEMPTS - 5'h01);
    wire crs_loss = watch_r & line_in.transmit_drive_enable & ~line_in.carrier_lost_flag;
    wire in_gap = phase_r == mtcs_pkg::PH_GAP;
    wire hb_miss = in_gap & (gap_cnt_r == mtcs_pkg::HB_LAST) & ~hb_seen_r & ~line_in.col;
    wire gave_any = result_r[mtcs_pkg::RES_GAVE_UP] | abort_coll;
    wire under_any = result_r[mtcs_pkg::RES_UNDERRUN] | line_in.underrun;
    wire [1:0] loop_mode = setup_r[mtcs_pkg::SET_LOOP_HI:mtcs_pkg::SET_LOOP_LO];
    wire [4:0] coll_n = clash_cnt_r + 5'h01;
    wire offset_on = setup_r[mtcs_pkg::SET_OFFSET] & (coll_n <= mtcs_pkg::OFFSET_COLLISIONS);
    wire [4:0] std_exp = (coll_n > mtcs_pkg::BACKOFF_MAX_EXP) ? mtcs_pkg::BACKOFF_MAX_EXP : coll_n;
    wire [4:0] backoff_exp = offset_on ? coll_n + mtcs_pkg::OFFSET_ADD : std_exp;
    wire [10:0] backoff_span = 11'h001 << backoff_exp[3:0];
    wire [9:0] backoff_mask = 10'(backoff_span - 11'h001);
    wire hash_off = line_in.mcast_hit & (line_in.mcast_idx == mtcs_pkg::HASH_DISABLE);
    wire hash_on = line_in.mcast_hit & (line_in.mcast_idx == mtcs_pkg::HASH_ENABLE);

    assign set_vec[mtcs_pkg::RES_SENT_OK] = line_in.done & ~gave_any & ~under_any;
    assign set_vec[1] = 1'b0;
    assign set_vec[mtcs_pkg::RES_COLLIDED] = col_edge;
    assign set_vec[mtcs_pkg::RES_GAVE_UP] = abort_coll;
    assign set_vec[mtcs_pkg::RES_CARRIER] = crs_loss;
    assign set_vec[mtcs_pkg::RES_UNDERRUN] = line_in.underrun;
    assign set_vec[mtcs_pkg::RES_HEARTBEAT] = hb_miss;
    assign set_vec[mtcs_pkg::RES_LATE] = late_hit;

    // Start clears, but an event in the same cycle still lands
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_result
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    result_r[gi] <= mtcs_pkg::RESULT_RST[gi];
                end else begin
                    result_r[gi] <= (result_r[gi] & ~line_in.start) | set_vec[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            mtcs_pkg::PH_IDLE: begin
                if (line_in.transmit_drive_enable) begin
                    phase_nxt = mtcs_pkg::PH_SEND;
                end
            end
            mtcs_pkg::PH_SEND: begin
                if (!line_in.transmit_drive_enable) begin
                    phase_nxt = mtcs_pkg::PH_GAP;
                end
            end
            mtcs_pkg::PH_GAP: begin
                if (line_in.transmit_drive_enable) begin
                    phase_nxt = mtcs_pkg::PH_SEND;
                end else if (gap_cnt_r == mtcs_pkg::HB_LAST) begin
                    phase_nxt = mtcs_pkg::PH_IDLE;
                end
            end
        endcase
    end

    // Collision count saturates at sixteen; start clears it, but a collision edge in the same cycle counts on from the old value
    always_comb begin
        clash_cnt_nxt = clash_cnt_r;
        if (line_in.start) begin
            clash_cnt_nxt = 5'h00;
        end
        if (col_edge && clash_cnt_r != mtcs_pkg::ABORT_ATTEMPTS) begin
            clash_cnt_nxt = coll_n;
        end
    end

    always_comb begin
        tx_en_nxt = tx_en_r;
        if (!setup_r[mtcs_pkg::SET_REMOTE_DIS]) begin
            tx_en_nxt = 1'b1;
        end else if (hash_off) begin
            tx_en_nxt = 1'b0;
        end else if (hash_on) begin
            tx_en_nxt = 1'b1;
        end
    end

    // Crc and loop outputs follow setup_nxt so they settle on the write edge itself
    always_comb begin
        ctl_nxt = '0;
        ctl_nxt.crc_append = ~setup_nxt[mtcs_pkg::SET_CRC_INHIBIT];
        ctl_nxt.internal_loop = setup_nxt[2:1] == mtcs_pkg::LOOP_INTERNAL;
        ctl_nxt.external_loop = setup_nxt[mtcs_pkg::SET_LOOP_HI];
        ctl_nxt.loop_pin = setup_nxt[2:1] == mtcs_pkg::LOOP_EXT_PIN;
        ctl_nxt.tx_enabled = tx_en_nxt;
        ctl_nxt.abort_frame = abort_coll | line_in.underrun;
        ctl_nxt.backoff_valid = col_edge & ~abort_coll;
        ctl_nxt.backoff_slots = col_edge ? (lfsr_r[9:0] & backoff_mask) : ctl_r.backoff_slots;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r <= mtcs_pkg::PH_IDLE;
            col_d_r <= 1'b0;
            clash_cnt_r <= 5'h00;
            tx_en_r <= 1'b1;
            lfsr_r <= mtcs_pkg::LFSR_SEED;
            ctl_r <= '{crc_append: 1'b1, tx_enabled: 1'b1, default: '0};
        end else begin
            phase_r <= phase_nxt;
            col_d_r <= line_in.col;
            clash_cnt_r <= clash_cnt_nxt;
            tx_en_r <= tx_en_nxt;
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            ctl_r <= ctl_nxt;
        end
    end

    // Carrier is judged only between end of preamble and enable drop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watch_r <= 1'b0;
        end else if (!line_in.transmit_drive_enable) begin
            watch_r <= 1'b0;
        end else if (line_in.preamble_done) begin
            watch_r <= 1'b1;
        end
    end

    // Slot timer runs from enable rise and sticks at the slot length
    always_ff @(posedge clk) begin
        if (sys_rst || phase_r != mtcs_pkg::PH_SEND) begin
            slot_cnt_r <= 10'h000;
        end else if (slot_cnt_r != mtcs_pkg::SLOT_COUNT) begin
            slot_cnt_r <= slot_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !in_gap) begin
            gap_cnt_r <= 7'h00;
            hb_seen_r <= 1'b0;
        end else begin
            gap_cnt_r <= gap_cnt_r + 7'h01;
            hb_seen_r <= hb_seen_r | line_in.col;
        end
    end

    assign line_out = ctl_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_setup_write;
        setup_wr;
    endsequence

    sequence s_coll_edge;
        col_edge;
    endsequence

    chk_crc_follows_setup: assert property (
        s_setup_write |=> line_out.crc_append == ~$past(avs_writedata[0]))
        else $error("crc append does not follow inhibit bit");

    chk_crc_in_loop: assert property (
        (line_out.internal_loop || line_out.external_loop) |->
            line_out.crc_append == ~setup_r[mtcs_pkg::SET_CRC_INHIBIT])
        else $error("crc setting ignored in loopback");

    chk_loop_decode: assert property (
        s_setup_write |=> line_out.external_loop == $past(avs_writedata[2]) &&
            line_out.internal_loop == ($past(avs_writedata[2:1]) == 2'h1))
        else $error("loop mode decode wrong");

    chk_loop_pin_mode: assert property (
        s_setup_write |=> line_out.loop_pin == ($past(avs_writedata[2:1]) == 2'h2))
        else $error("loop pin not high only in mode 2");

    chk_loop_reset: assert property (
        $past(sys_rst) |-> setup_r[2:1] == 2'h0 && !line_out.loop_pin)
        else $error("loop bits not zero after reset");

    chk_remote_off: assert property (
        setup_r[mtcs_pkg::SET_REMOTE_DIS] && hash_off |=> !line_out.tx_enabled)
        else $error("hash 62 did not disable transmitter");

    chk_remote_clear: assert property (
        s_setup_write ##0 !avs_writedata[3] |=> ##1 line_out.tx_enabled)
        else $error("clearing remote disable did not re-enable");

    chk_offset_range: assert property (
        s_coll_edge ##0 (setup_r[mtcs_pkg::SET_OFFSET] && clash_cnt_r < 5'h03) |=>
            (line_out.backoff_slots >> ($past(clash_cnt_r) + 5'h04)) == 10'h000)
        else $error("offset backoff out of range");

    chk_clear_on_start: assert property (
        line_in.start && set_vec == 8'h00 |=> result_r == 8'h00)
        else $error("result not cleared on start");

    chk_flag_sticky: assert property (
        !line_in.start |=> (result_r & $past(result_r)) == $past(result_r))
        else $error("result bit dropped without start");

    chk_sent_ok: assert property (
        line_in.done && !line_in.start && !result_r[mtcs_pkg::RES_SENT_OK] |=>
            result_r[mtcs_pkg::RES_SENT_OK] !=
            (result_r[mtcs_pkg::RES_GAVE_UP] | result_r[mtcs_pkg::RES_UNDERRUN]))
        else $error("sent ok wrong at completion");

    chk_collided_count: assert property (
        s_coll_edge ##0 (!line_in.start && clash_cnt_r < 5'h10) |=>
            result_r[mtcs_pkg::RES_COLLIDED] && clash_cnt_r == $past(clash_cnt_r) + 5'h01)
        else $error("collision not recorded");

    chk_abort_sixteen: assert property (
        s_coll_edge ##0 clash_cnt_r == 5'h0f |=>
            result_r[mtcs_pkg::RES_GAVE_UP] && line_out.abort_frame && !line_out.backoff_valid)
        else $error("no abort on sixteenth attempt");

    chk_carrier_loss: assert property (
        watch_r && line_in.transmit_drive_enable && !line_in.carrier_lost_flag && !abort_coll && !line_in.underrun |=>
            result_r[mtcs_pkg::RES_CARRIER] && !line_out.abort_frame [*1])
        else $error("carrier loss not flagged");

    chk_underrun_abort: assert property (
        line_in.underrun |=> result_r[mtcs_pkg::RES_UNDERRUN] && line_out.abort_frame)
        else $error("underrun not flagged or not aborted");

    chk_heartbeat_miss: assert property (
        phase_r == mtcs_pkg::PH_SEND && !line_in.transmit_drive_enable ##1 (!line_in.col && !line_in.transmit_drive_enable
            && !line_in.start) [*8] |-> ##56 (!line_in.col && !line_in.transmit_drive_enable) |=>
            result_r[mtcs_pkg::RES_HEARTBEAT] || $past(hb_seen_r))
        else $error("missing heartbeat not flagged");

    chk_late_collision: assert property (
        s_coll_edge ##0 (slot_cnt_r >= mtcs_pkg::SLOT_COUNT && clash_cnt_r < 5'h0f) |=>
            result_r[mtcs_pkg::RES_LATE] && line_out.backoff_valid)
        else $error("late collision not flagged or not rescheduled");

    chk_late_not_early: assert property (
        s_coll_edge ##0 (slot_cnt_r < mtcs_pkg::SLOT_COUNT && !line_in.start
            && !result_r[mtcs_pkg::RES_LATE]) |=> !result_r[mtcs_pkg::RES_LATE])
        else $error("late flag set inside slot time");

    chk_std_backoff: assert property (
        s_coll_edge ##0 (clash_cnt_r < 5'h0a && (!setup_r[mtcs_pkg::SET_OFFSET]
            || clash_cnt_r >= 5'h03)) |=>
            (line_out.backoff_slots >> ($past(clash_cnt_r) + 5'h01)) == 10'h000)
        else $error("standard backoff out of range");

    chk_gap_not_collision: assert property (
        line_in.col && !line_in.transmit_drive_enable && !line_in.start |=> $stable(clash_cnt_r))
        else $error("heartbeat counted as collision");

    chk_remote_on: assert property (
        setup_r[mtcs_pkg::SET_REMOTE_DIS] && hash_on |=> line_out.tx_enabled)
        else $error("hash 63 did not re-enable transmitter");

    chk_remote_hold: assert property (
        setup_r[mtcs_pkg::SET_REMOTE_DIS] && !line_out.tx_enabled && !hash_on |=>
            !line_out.tx_enabled)
        else $error("disabled transmitter came back without hash 63");

    chk_normal_mode: assert property (
        s_setup_write ##0 avs_writedata[2:1] == 2'h0 |=>
            !line_out.internal_loop && !line_out.external_loop && !line_out.loop_pin)
        else $error("loop output active in normal mode");

    chk_abort_cause: assert property (
        line_out.abort_frame |-> $past(abort_coll) || $past(line_in.underrun))
        else $error("abort without collision limit or underrun");

endmodule

// File: dv/mtcs_partner.sv
// Serial link chip and transceiver model: carrier echo, heartbeat, collisions
`timescale 1ns/1ps
module mtcs_partner (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic transmit_drive_enable,
    input wire logic lose_crs,
    input wire logic skip_hb,
    input wire logic col_req,
    output logic carrier_lost_flag,
    output logic col
);
    // ==========================================================
    // Carrier and heartbeat
    logic transmit_drive_enable_d;
    logic [4:0] hb_cnt;
    logic hb_on;

    assign hb_on = (hb_cnt >= 5'h05) && (hb_cnt < 5'h0f);
    assign col = col_req | hb_on;

    always_ff @(posedge clk) begin
        transmit_drive_enable_d <= transmit_drive_enable;
        // Own carrier seen one cycle late, as through a real transceiver
        carrier_lost_flag <= transmit_drive_enable & ~lose_crs;
        if (sys_rst) begin
            hb_cnt <= 5'h00;
        end else if (transmit_drive_enable_d & ~transmit_drive_enable & ~skip_hb) begin
            hb_cnt <= 5'h01;
        end else if (hb_cnt != 5'h00) begin
            hb_cnt <= hb_cnt + 5'h01;
        end
    end
endmodule

// File: dv/mtcs_tb_top.sv
// Self-checking bench for the transmit setup and result registers
`timescale 1ns/1ps
module mtcs_tb_top;
    // ==========================================================
    // Signals
    logic clk;
    logic sys_rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] ev;
    logic transmit_drive_enable, lose_crs, skip_hb, col_req, crs_w, col_w, mh;
    logic [5:0] midx;
    logic ofs;
    mtcs_pkg::mtcs_line_in_s line_in_w;
    mtcs_pkg::mtcs_line_out_s line_out_w;
    int bad_count = 0;
    int n_checks = 0;
    int bo_cnt = 0;
    int ab_cnt = 0;

    assign line_in_w = {ev[0], ev[1], ev[2], ev[3], col_w, crs_w, transmit_drive_enable, mh, midx};

    mtcs_top mtcs_top_inst (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .line_in(line_in_w), .line_out(line_out_w)
    );

    mtcs_partner mtcs_partner_inst (
        .clk(clk), .sys_rst(sys_rst), .transmit_drive_enable(transmit_drive_enable), .lose_crs(lose_crs),
        .skip_hb(skip_hb), .col_req(col_req), .carrier_lost_flag(crs_w), .col(col_w)
    );

    // ==========================================================
    // Compare and bus tasks
    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, bounded
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        int i;
        i = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // A hung slave ends the run here rather than stalling every later check
        if (i >= 50) begin
            bad_count++;
            $display("FAIL %0t bus answer missing", $time);
            wrap_up();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_xfer(1'b0, a, 32'h0000_0000, d);
        chk_word(d, exp);
    endtask

    task automatic wr_setup(input logic [31:0] v);
        logic [31:0] d;
        bus_xfer(1'b1, mtcs_pkg::ADDR_SETUP, v, d);
        @(posedge clk);
    endtask

    task automatic ev_pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask

    task automatic mcast(input logic [5:0] h, input logic exp);
        @(posedge clk);
        mh <= 1'b1;
        midx <= h;
        @(posedge clk);
        mh <= 1'b0;
        @(posedge clk);
        chk_bit(line_out_w.tx_enabled, exp);
    endtask

    // ev: 0 start, 1 preamble done, 2 done, 3 underrun
    task automatic frame(input logic lose, input logic nohb, input int ncol, input int late,
                         input logic urun);
        ev_pulse(0);
        bo_cnt = 0;
        ab_cnt = 0;
        if (urun) begin
            ev_pulse(3);
        end else begin
            @(posedge clk);
            transmit_drive_enable <= 1'b1;
            repeat (3) @(posedge clk);
            ev_pulse(1);
            repeat (late) @(posedge clk);
            for (int i = 0; i < ncol; i++) begin
                col_req <= 1'b1;
                repeat (2) @(posedge clk);
                col_req <= 1'b0;
                repeat (2) @(posedge clk);
            end
            lose_crs <= lose;
            skip_hb <= nohb;
            repeat (4) @(posedge clk);
            transmit_drive_enable <= 1'b0;
            repeat (70) @(posedge clk);
        end
        ev_pulse(2);
        lose_crs <= 1'b0;
        skip_hb <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    function automatic int slot_lim(input int n);
        int k;
        k = (ofs && n <= 3) ? n + 3 : ((n < 10) ? n : 10);
        return 1 << k;
    endfunction

    // ==========================================================
    // Line-side monitor
    always @(posedge clk) begin
        if (line_out_w.backoff_valid === 1'b1) begin
            bo_cnt++;
            chk_bit(({22'h00_0000, line_out_w.backoff_slots} < slot_lim(bo_cnt)), 1'b1);
        end
        if (line_out_w.abort_frame === 1'b1) begin
            ab_cnt++;
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #3_000_000;
        bad_count++;
        wrap_up();
    end

    // ==========================================================
    // Tests
    initial begin
        logic [2:0] m;
        sys_rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'h1;
        {ev, transmit_drive_enable, lose_crs, skip_hb, col_req, mh, midx, ofs} = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk_word({28'h000_0000, line_out_w.crc_append, line_out_w.internal_loop,
                  line_out_w.external_loop, line_out_w.loop_pin}, 32'h0000_0008);
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            // Host keeps data config bit 3 clear for loopback; that register is not modelled
            wr_setup({29'h0000_0000, m});
            chk_bit(line_out_w.crc_append, ~m[0]);
            chk_bit(line_out_w.internal_loop, m[2:1] == 2'h1);
            chk_bit(line_out_w.external_loop, m[2]);
            chk_bit(line_out_w.loop_pin, m[2:1] == 2'h2);
        end
        rd_chk(mtcs_pkg::ADDR_SETUP, 32'h0000_0000);
        rd_chk(8'h00, 32'h0000_0000);
        wr_setup(32'h0000_0000);
        frame(1'b1, 1'b1, 0, 0, 1'b0);
        rd_chk(mtcs_pkg::ADDR_RESULT, 32'h0000_0051);
        frame(1'b0, 1'b0, 0, 0, 1'b0);
        rd_chk(mtcs_pkg::ADDR_RESULT, 32'h0000_0001);
        frame(1'b0, 1'b0, 0, 0, 1'b1);
        rd_chk(mtcs_pkg::ADDR_RESULT, 32'h0000_0020);
        chk_word(32'(ab_cnt), 32'h0000_0001);
        ofs = 1'b1;
        wr_setup(32'h0000_0010);
        frame(1'b0, 1'b0, 16, 0, 1'b0);
        rd_chk(mtcs_pkg::ADDR_RESULT, 32'h0000_000c);
        rd_chk(mtcs_pkg::ADDR_CLASH, 32'h0000_0090);
        chk_word(32'(bo_cnt), 32'h0000_000f);
        chk_word(32'(ab_cnt), 32'h0000_0001);
        ofs = 1'b0;
        wr_setup(32'h0000_0000);
        frame(1'b0, 1'b0, 1, 520, 1'b0);
        rd_chk(mtcs_pkg::ADDR_RESULT, 32'h0000_0085);
        chk_word(32'(bo_cnt), 32'h0000_0001);
        mcast(mtcs_pkg::HASH_DISABLE, 1'b1);
        wr_setup(32'h0000_0008);
        mcast(mtcs_pkg::HASH_DISABLE, 1'b0);
        mcast(mtcs_pkg::HASH_ENABLE, 1'b1);
        mcast(mtcs_pkg::HASH_DISABLE, 1'b0);
        wr_setup(32'h0000_0000);
        @(posedge clk);
        chk_bit(line_out_w.tx_enabled, 1'b1);
        wrap_up();
    end
endmodule
